/* File: hw/nps_top.sv */
// Protection register, command status register and launch checks of the NVM controller.
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "nps_params.svh"
// Functional notes
// RQ1: Protection loads from stored byte at reset.
// RQ2: Software reprograms stored byte, then resets.
// RQ3: Protection readable; writes may only tighten.
// RQ4: Bits 7:6 choose protected EEPROM top range.
// RQ5: Bits 5:0 choose protected FLASH top range.
// RQ6: EEPROM bits writable for temporary tightening.
// RQ7: Debug interface may rewrite protection freely.
// RQ8: Protected target refused, violation flag set.
// RQ9: Mass erase refused if anything protected.
// RQ10: Buffer-empty flag write-one launches command.
// RQ11: Complete flag follows idle; clears on launch.
// RQ12: Bad sequence or no divider sets error; the code checks the divider for program and erase codes only.
// RQ13: Stop during command sets access error.
// RQ14: Access error clears only by writing one.
// RQ15: Blank check result sets blank flag.
// RQ16: Blank flag clears on valid launch only.
// RQ17: Unknown command codes raise access error.
// RQ18: Status bits 3,1,0 read zero.
// RQ19: Flags update on clock; set beats clear.
module nps_top
  import nps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] stored_protection_byte,
  input wire logic bdm_prot_wr,
  input wire logic [7:0] bdm_prot_data,
  input wire logic div_init_done,
  input wire logic stop_mode,
  input wire nps_seq_s seq_i,
  output logic cmd_start_o,
  output nps_cmd_s cmd_o,
  output logic [7:0] prot_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] prot_q;
  logic [7:0] code_q;
  logic [15:0] addr_q;
  logic cbef_q;
  logic ccf_q;
  logic pviol_q;
  logic accerr_q;
  logic blank_q;
  logic blank_cmd_q;
  logic start_q;
  nps_cmd_s cmd_q;
  nps_seq_e st_q;
  nps_seq_e st_d;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire logic req = wb_cyc_i & wb_stb_i & ~ack_q;
  // Writes commit at the edge where the master sees ack, so a cycle that is
  // abandoned before its answer leaves every register untouched.
  wire logic wr = wb_cyc_i & wb_stb_i & ack_q & wb_we_i;
  wire logic lane0 = wb_sel_i[0];
  wire logic hit_prot = wb_adr_i == `NPS_OFS_PROT;
  wire logic hit_stat = wb_adr_i == `NPS_OFS_STAT;
  wire logic hit_cmd = wb_adr_i == `NPS_OFS_CMD;
  wire logic hit_addr = wb_adr_i == `NPS_OFS_ADDR;
  wire logic wr_prot = wr & hit_prot & lane0;
  wire logic wr_stat = wr & hit_stat & lane0;
  wire logic wr_cmd = wr & hit_cmd & lane0;
  wire logic wr_addr = wr & hit_addr & (|wb_sel_i[1:0]);
  wire logic w1c_pviol = wr_stat & wb_dat_i[`NPS_BIT_PVIOL];
  wire logic w1c_accerr = wr_stat & wb_dat_i[`NPS_BIT_ACCERR];
  wire logic launch = wr_stat & wb_dat_i[`NPS_BIT_CBEF] & cbef_q; // RQ10
  wire logic [15:0] addr_wr = {
    wb_sel_i[1] ? wb_dat_i[15:8] : addr_q[15:8],
    wb_sel_i[0] ? wb_dat_i[7:0] : addr_q[7:0]
  };

  // ---------------------------------------------------------------
  // Protection windows
  // ---------------------------------------------------------------
  wire logic [1:0] eeprom_protect_select = prot_q[`NPS_EPS_HI:`NPS_EPS_LO];
  wire logic [5:0] flash_protect_select = prot_q[`NPS_FPS_HI:`NPS_FPS_LO];
  wire logic [5:0] fl_steps = `NPS_FPS_NONE - flash_protect_select;
  wire logic [16:0] fl_span = 17'(fl_steps) * `NPS_FL_STEP;
  wire logic [16:0] fl_lo17 = `NPS_FL_END - fl_span;
  wire logic fl_all = flash_protect_select <= `NPS_FPS_ALL;
  wire logic [15:0] fl_lo = fl_all ? 16'h0000 : fl_lo17[15:0]; // RQ5
  wire logic fl_en = flash_protect_select != `NPS_FPS_NONE;
  wire logic ee_en = eeprom_protect_select != `NPS_EPS_NONE;
  wire logic [15:0] ee_lo = (eeprom_protect_select == 2'h2) ? `NPS_EE_LO2 :
    (eeprom_protect_select == 2'h1) ? `NPS_EE_LO1 : `NPS_EE_LO0; // RQ4
  wire logic fl_hit;
  wire logic ee_hit;

  nps_range_hit #(.AW(16)) u_fl_win (
    .en(fl_en),
    .lo(fl_lo),
    .hi(`NPS_FL_TOP),
    .addr(addr_q),
    .hit(fl_hit)
  );

  nps_range_hit #(.AW(16)) u_ee_win (
    .en(ee_en),
    .lo(ee_lo),
    .hi(`NPS_EE_TOP),
    .addr(addr_q),
    .hit(ee_hit)
  );

  // A write whose field value is larger would uncover memory. All FLASH
  // codes up to the full-array code protect the same area.
  wire logic [1:0] new_eps = wb_dat_i[`NPS_EPS_HI:`NPS_EPS_LO];
  wire logic [5:0] new_fps = wb_dat_i[`NPS_FPS_HI:`NPS_FPS_LO];
  wire logic fps_ok = (new_fps <= flash_protect_select) | (new_fps <= `NPS_FPS_ALL);
  wire logic prot_grow = (new_eps <= eeprom_protect_select) & fps_ok; // RQ3 RQ6
  wire logic prot_take = wr_prot & prot_grow & ~bdm_prot_wr;

  // ---------------------------------------------------------------
  // Launch checks
  // ---------------------------------------------------------------
  wire logic is_blank = code_q == `NPS_CMD_BLANK;
  wire logic is_merase = code_q == `NPS_CMD_MERASE;
  wire logic is_pe = (code_q == `NPS_CMD_BYTE) | (code_q == `NPS_CMD_BURST) |
    (code_q == `NPS_CMD_SERASE) | is_merase;
  wire logic code_ok = is_pe | is_blank | (code_q == `NPS_CMD_ABORT); // RQ17
  wire logic any_prot = fl_en | ee_en;
  wire logic in_cmd = st_q == SQ_CMD;
  wire logic bad_launch = launch & (~in_cmd | ~code_ok |
    (is_pe & ~div_init_done) | pviol_q | accerr_q); // RQ12 RQ17
  wire logic viol = launch & ~bad_launch & is_pe &
    (fl_hit | ee_hit | (is_merase & any_prot)); // RQ8 RQ9
  wire logic launch_ok = launch & ~bad_launch & ~viol;
  wire logic bad_addr = wr_addr & ((st_q != SQ_IDLE) | ~cbef_q);
  wire logic bad_cmd = wr_cmd & (st_q != SQ_ADDR);
  wire logic seq_err = bad_launch | bad_addr | bad_cmd; // RQ12
  wire logic stop_err = stop_mode & ~ccf_q; // RQ13
  wire logic blank_set = seq_i.done & seq_i.blank_ok & blank_cmd_q; // RQ15

  // ---------------------------------------------------------------
  // Command sequence
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      SQ_IDLE:
      begin
        if (wr_addr & cbef_q)
          st_d = SQ_ADDR;
        else if (wr_cmd | launch)
          st_d = SQ_IDLE;
      end
      SQ_ADDR:
      begin
        if (wr_cmd)
          st_d = SQ_CMD;
        else if (wr_addr | launch)
          st_d = SQ_IDLE;
      end
      SQ_CMD:
      begin
        if (launch | wr_addr | wr_cmd)
          st_d = SQ_IDLE;
      end
      default:
      begin
        st_d = SQ_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  wire logic [7:0] stat_val = {cbef_q, ccf_q, pviol_q, accerr_q,
    1'b0, blank_q, 2'b00}; // RQ18
  wire logic [31:0] rd_mux = hit_prot ? {24'h000000, prot_q} :
    hit_stat ? {24'h000000, stat_val} :
    hit_cmd ? {24'h000000, code_q} :
    hit_addr ? {16'h0000, addr_q} : 32'h00000000;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      st_q <= SQ_IDLE;
    end
    else
    begin
      ack_q <= req;
      rdat_q <= rd_mux;
      st_q <= st_d;
    end
  end

  // The stored byte is taken on every reset cycle, so it is in force at release.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      prot_q <= stored_protection_byte; // RQ1
    else if (bdm_prot_wr)
      prot_q <= bdm_prot_data; // RQ7
    else if (prot_take)
      prot_q <= wb_dat_i[7:0]; // RQ3
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      code_q <= `NPS_CODE_RST;
      addr_q <= `NPS_ADDR_RST;
    end
    else
    begin
      if (wr_cmd)
        code_q <= wb_dat_i[7:0];
      if (wr_addr)
        addr_q <= addr_wr;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cbef_q <= `NPS_CBEF_RST;
      ccf_q <= `NPS_CCF_RST;
    end
    else
    begin
      cbef_q <= seq_i.take | (cbef_q & ~launch_ok); // RQ10
      ccf_q <= cbef_q & ~launch_ok & ~seq_i.busy; // RQ11
    end
  end

  // Set wins over a write-one clear that lands in the same cycle.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pviol_q <= 1'b0;
      accerr_q <= 1'b0;
      blank_q <= 1'b0;
    end
    else
    begin
      pviol_q <= viol | (pviol_q & ~w1c_pviol); // RQ8 RQ19
      accerr_q <= seq_err | stop_err | (accerr_q & ~w1c_accerr); // RQ14 RQ19
      blank_q <= blank_set | (blank_q & ~launch_ok); // RQ15 RQ16
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      blank_cmd_q <= 1'b0;
      start_q <= 1'b0;
      cmd_q <= '0;
    end
    else
    begin
      start_q <= launch_ok;
      if (launch_ok)
      begin
        blank_cmd_q <= is_blank;
        cmd_q <= '{code: code_q, addr: addr_q};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign cmd_start_o = start_q;
  assign cmd_o = cmd_q;
  assign prot_o = prot_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_wb_answer: assert property (req |=> s_ack_pulse)
    else $error("bus answer not a one-cycle ack");
  chk_reset_load: assert property ($rose(rst_n) |-> // RQ1
    prot_q == $past(stored_protection_byte))
    else $error("protection not loaded from stored byte");
  chk_prot_tighten: assert property (wr_prot & ~prot_grow & ~bdm_prot_wr // RQ3
    |=> prot_q == $past(prot_q))
    else $error("loosening protection write took effect");
  chk_bdm_write: assert property (bdm_prot_wr |=> // RQ7
    prot_q == $past(bdm_prot_data))
    else $error("debug protection write lost");
  chk_pviol_refuse: assert property (viol |=> pviol_q & !cmd_start_o // RQ8
    ##1 !cmd_start_o)
    else $error("protected command not refused");
  chk_merase_refused: assert property (launch & in_cmd & is_merase & // RQ9
    any_prot |=> !cmd_start_o)
    else $error("mass erase launched while protected");
  chk_launch_flags: assert property (launch_ok |=> !cbef_q & !ccf_q & // RQ10 RQ11
    cmd_start_o ##1 !cmd_start_o)
    else $error("launch flags wrong");
  chk_take_refill: assert property (seq_i.take |=> cbef_q) // RQ10
    else $error("buffer-empty flag not set after take");
  chk_busy_ccf: assert property (seq_i.busy |=> !ccf_q) // RQ11
    else $error("complete flag set while array busy");
  chk_accerr_hold: assert property (accerr_q & !w1c_accerr |=> accerr_q) // RQ14
    else $error("access error cleared without write of one");
  chk_stop_err: assert property (stop_mode & !ccf_q |=> accerr_q) // RQ13
    else $error("stop during command not flagged");
  chk_bad_code: assert property (launch & in_cmd & !code_ok |=> // RQ17
    accerr_q & !cmd_start_o)
    else $error("unknown code not refused");
  chk_blank_set: assert property (blank_set |=> blank_q) // RQ15
    else $error("blank result not flagged");
  chk_blank_clear: assert property (launch_ok & !blank_set |=> !blank_q) // RQ16
    else $error("blank flag kept over launch");
  chk_rsvd_zero: assert property (req & hit_stat |=> // RQ18
    (wb_dat_o[3] == 1'b0) & (wb_dat_o[1:0] == 2'b00))
    else $error("unused status bits not zero");
endmodule : nps_top

/* File: hw/nps_params.svh */
// Offsets, field positions, reset values and command codes of the protection block.
`ifndef NPS_PARAMS_SVH
`define NPS_PARAMS_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define NPS_OFS_PROT 8'h00
`define NPS_OFS_STAT 8'h04
`define NPS_OFS_CMD 8'h08
`define NPS_OFS_ADDR 8'h0c
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define NPS_EPS_HI 7
`define NPS_EPS_LO 6
`define NPS_FPS_HI 5
`define NPS_FPS_LO 0
`define NPS_BIT_CBEF 7
`define NPS_BIT_CCF 6
`define NPS_BIT_PVIOL 5
`define NPS_BIT_ACCERR 4
`define NPS_BIT_BLANK 2
// ---------------------------------------------------------------
// Protection ranges
// ---------------------------------------------------------------
`define NPS_EPS_NONE 2'h3
`define NPS_FPS_NONE 6'h3f
`define NPS_FPS_ALL 6'h18
`define NPS_FL_STEP 17'h00600
`define NPS_FL_END 17'h10000
`define NPS_FL_TOP 16'hffff
`define NPS_EE_TOP 16'h17ff
`define NPS_EE_LO2 16'h17f0
`define NPS_EE_LO1 16'h17e0
`define NPS_EE_LO0 16'h17c0
// ---------------------------------------------------------------
// Command codes and reset values
// ---------------------------------------------------------------
`define NPS_CMD_BLANK 8'h05
`define NPS_CMD_BYTE 8'h20
`define NPS_CMD_BURST 8'h25
`define NPS_CMD_SERASE 8'h40
`define NPS_CMD_MERASE 8'h41
`define NPS_CMD_ABORT 8'h47
`define NPS_CBEF_RST 1'b1
`define NPS_CCF_RST 1'b1
`define NPS_CODE_RST 8'h00
`define NPS_ADDR_RST 16'h0000
`endif

/* File: hw/nps_pkg.sv */
// Types shared by the protection and status block.
package nps_pkg;
  typedef enum logic [2:0]
  {
    SQ_IDLE = 3'b001,
    SQ_ADDR = 3'b010,
    SQ_CMD = 3'b100
  } nps_seq_e;

  typedef struct packed
  {
    logic [7:0] code;
    logic [15:0] addr;
  } nps_cmd_s;

  typedef struct packed
  {
    logic take;
    logic busy;
    logic done;
    logic blank_ok;
  } nps_seq_s;
endpackage : nps_pkg

/* File: hw/nps_range_hit.sv */
// Address window compare used for each protected region.
`timescale 1ns/10ps
module nps_range_hit #(
  parameter int AW = 16
) (
  input wire logic en,
  input wire logic [AW-1:0] lo,
  input wire logic [AW-1:0] hi,
  input wire logic [AW-1:0] addr,
  output logic hit
);
  if (AW < 2)
  begin : g_chk
    $error("nps_range_hit: AW too small");
  end

  assign hit = en & (addr >= lo) & (addr <= hi);
endmodule : nps_range_hit

/* File: sim/tb.sv */
// Self-checking bench for the protection and status block.
`timescale 1ns/10ps
module tb
  import nps_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] nv_byte = 8'h7b;
  logic bdm_wr = 1'b0;
  logic [7:0] bdm_dat = 8'h00;
  logic div_ok = 1'b1;
  logic stop = 1'b0;
  nps_seq_s seq = '0;
  logic cmd_start_o;
  nps_cmd_s cmd_o;
  logic [7:0] prot_o;
  int error_cnt = 0;
  int compares = 0;
  int starts = 0;
  nps_cmd_s last_cmd;
  logic [31:0] q;
  logic [7:0] p, c, e;
  logic [15:0] a;
  logic [7:0] codes [6] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47};
  logic [7:0] cc [4] = '{8'h20, 8'h25, 8'h40, 8'h41};
  logic [7:0] cp [4] = '{8'hbe, 8'hbe, 8'hd9, 8'hd8};
  logic [15:0] ca [4] = '{16'h17ef, 16'hfa00, 16'h1bff, 16'h0000};

  always #5 ref_clk = ~ref_clk;

  nps_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stored_protection_byte(nv_byte),
    .bdm_prot_wr(bdm_wr), .bdm_prot_data(bdm_dat), .div_init_done(div_ok),
    .stop_mode(stop), .seq_i(seq), .cmd_start_o(cmd_start_o), .cmd_o(cmd_o),
    .prot_o(prot_o));

  always @(posedge ref_clk)
    if (cmd_start_o === 1'b1)
    begin
      starts++;
      last_cmd = cmd_o;
    end

  // ---------------------------------------------------------------
  // Stimulus helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic wb(input logic we, input logic [7:0] ad, input logic [3:0] s,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
    begin
      error_cnt++;
      report_and_stop();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic st(input logic [7:0] ex);
    wb(1'b0, 8'h04, 4'hf, 32'h0);
    chk(q, {24'h0, ex});
  endtask : st

  task automatic rst_seq(input logic [7:0] v);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    nv_byte <= v;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
  endtask : rst_seq

  task automatic bdm(input logic [7:0] v);
    @(posedge ref_clk);
    bdm_wr <= 1'b1;
    bdm_dat <= v;
    @(posedge ref_clk);
    bdm_wr <= 1'b0;
    @(posedge ref_clk);
    chk({24'h0, prot_o}, {24'h0, v});
  endtask : bdm

  task automatic launch(input logic [7:0] cd, input logic [15:0] ad, input logic [7:0] ex);
    int s0;
    s0 = starts;
    wb(1'b1, 8'h0c, 4'h3, {16'h0, ad});
    wb(1'b1, 8'h08, 4'h1, {24'h0, cd});
    wb(1'b1, 8'h04, 4'h1, 32'h80);
    st(ex);
    chk(32'(starts - s0), (ex == 8'h00) ? 32'h1 : 32'h0);
    if (ex == 8'h00)
      chk({8'h0, last_cmd}, {8'h0, cd, ad});
  endtask : launch

  // The array side answers only for a launched command; otherwise flags are just cleared.
  task automatic fin(input logic go, input logic bl, input logic [7:0] ex);
    if (go)
    begin
      @(posedge ref_clk);
      seq <= '{1'b1, 1'b1, 1'b0, 1'b0};
      @(posedge ref_clk);
      seq <= '{1'b0, 1'b1, 1'b0, 1'b0};
      st(ex & 8'h90);
      seq <= '{1'b0, 1'b0, 1'b1, bl};
      @(posedge ref_clk);
      seq <= '0;
      repeat (3) @(posedge ref_clk);
    end
    st(ex);
    wb(1'b1, 8'h04, 4'h1, 32'h30);
    st(8'hc0 | (ex & 8'h04));
  endtask : fin

  function automatic logic hit(input logic [7:0] v, input logic [15:0] ad,
    input logic [7:0] cd);
    logic [16:0] lo;
    lo = 17'h10000 - 17'(6'h3f - v[5:0]) * 17'h00600;
    if (cd == 8'h41)
      return v != 8'hff;
    if (v[5:0] <= 6'h18 || {1'b0, ad} >= lo)
      return 1'b1;
    return v[7:6] != 2'h3 && ad >= 16'h1800 - (16'h10 << (2'h2 - v[7:6])) && ad <= 16'h17ff;
  endfunction : hit

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(68));
    rst_seq(8'h7b);
    chk({24'h0, prot_o}, 32'h7b);
    st(8'hc0);
    rst_seq(8'hbe);
    wb(1'b0, 8'h00, 4'hf, 32'h0);
    chk(q, 32'hbe);
    wb(1'b1, 8'h00, 4'h1, 32'hff);
    wb(1'b0, 8'h00, 4'hf, 32'h0);
    chk(q, 32'hbe);
    wb(1'b1, 8'h00, 4'h1, 32'h3a);
    wb(1'b0, 8'h00, 4'hf, 32'h0);
    chk(q, 32'h3a);
    wb(1'b1, 8'h00, 4'h1, 32'h7a);
    wb(1'b0, 8'h00, 4'hf, 32'h0);
    chk(q, 32'h3a);
    wb(1'b1, 8'h10, 4'hf, 32'hffffffff);
    wb(1'b0, 8'h10, 4'hf, 32'h0);
    chk(q, 32'h0);
    bdm(8'hff);
    for (int i = 0; i < 6; i++)
    begin
      launch(codes[i], 16'h8000, 8'h00);
      fin(1'b1, 1'b0, 8'hc0);
    end
    launch(8'h05, 16'h0000, 8'h00);
    fin(1'b1, 1'b1, 8'hc4);
    wb(1'b1, 8'h04, 4'h1, 32'h04);
    st(8'hc4);
    launch(8'h05, 16'h0000, 8'h00);
    fin(1'b1, 1'b0, 8'hc0);
    launch(8'h21, 16'h8000, 8'hd0);
    wb(1'b1, 8'h04, 4'h1, 32'h4f);
    st(8'hd0);
    fin(1'b0, 1'b0, 8'hd0);
    wb(1'b1, 8'h08, 4'h1, 32'h20);
    wb(1'b1, 8'h04, 4'h1, 32'h80);
    st(8'hd0);
    fin(1'b0, 1'b0, 8'hd0);
    div_ok <= 1'b0;
    launch(8'h20, 16'h8000, 8'hd0);
    div_ok <= 1'b1;
    fin(1'b0, 1'b0, 8'hd0);
    launch(8'h20, 16'h8000, 8'h00);
    @(posedge ref_clk);
    stop <= 1'b1;
    @(posedge ref_clk);
    stop <= 1'b0;
    st(8'h10);
    fin(1'b1, 1'b0, 8'hd0);
    for (int i = 0; i < 40; i++)
    begin
      p = (i < 4) ? cp[i] : 8'($urandom);
      a = (i < 4) ? ca[i] : (($urandom % 2) ? 16'h17c0 + 16'($urandom % 64) : 16'($urandom));
      c = (i < 4) ? cc[i] : cc[$urandom % 4];
      bdm(p);
      e = hit(p, a, c) ? 8'he0 : 8'h00;
      launch(c, a, e);
      fin(e == 8'h00, 1'b0, (e == 8'h00) ? 8'hc0 : 8'he0);
    end
    report_and_stop();
  end
endmodule : tb
